// >>> logic/vcom_pkg.sv
// Constants, types and register map of the virtual COM port serial bridge
//
// Overview of operation
// - Reset gives 115200 8N1, handshake off
// - Baud 9600 to 921600, both directions
// - Clear-to-send drops when receive buffer full
// - Gated mode holds new bytes while rts low
// - Byte in progress always completes
// - Disabled mode: cts undriven, rts ignored
// - Rts mode: drive cts, ignore rts
// - Cts mode: cts undriven, gate on rts
// - Combined mode: drive cts and gate
package vcom_pkg;

  // ==========================================================================
  // Clock and line rates
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned BAUD_RESET = 115_200;
  localparam int unsigned BAUD_MIN   = 9_600;
  localparam int unsigned BAUD_MAX   = 921_600;
  localparam int unsigned DATA_BITS  = 8;

  // Clock cycles per bit; the divisor range follows from the baud range
  localparam logic [15:0] DIV_RESET = 16'((CLK_HZ + BAUD_RESET / 2) / BAUD_RESET);
  localparam logic [15:0] DIV_FLOOR = 16'(CLK_HZ / BAUD_MAX);
  localparam int unsigned DIV_CEIL  = CLK_HZ / BAUD_MIN;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BAUD   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned STAT_TX_SPACE   = 0;
  localparam int unsigned STAT_RX_AVAIL   = 1;
  localparam int unsigned STAT_TX_BUSY    = 2;
  localparam int unsigned STAT_OVERRUN    = 3;
  localparam int unsigned STAT_FRAMING    = 4;
  localparam int unsigned STAT_CTS_LEVEL  = 5;
  localparam int unsigned STAT_RTS_LEVEL  = 6;

  // ==========================================================================
  // Handshake modes, encoded in order 0..3
  typedef enum logic [1:0] {
    hs_disabled,
    hs_rts,
    hs_cts,
    hs_rtscts
  } handshake_type;

  localparam handshake_type MODE_RESET = hs_disabled;

  // Serial engine states
  typedef enum logic [1:0] {
    ser_idle,
    ser_start,
    ser_data,
    ser_stop
  } ser_state_type;

endpackage : vcom_pkg

// >>> logic/byte_buf_if.sv
// Valid/ready byte channel between the serial engines and their buffers
`timescale 1ns/1ps
interface byte_buf_if;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;

  modport producer (output in_valid, output in_data, input in_ready);
  modport store    (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
  modport consumer (input out_valid, input out_data, output out_ready);
endinterface : byte_buf_if

// >>> logic/two_entry_buf.sv
// Two-entry byte buffer with registered head output
`timescale 1ns/1ps
module two_entry_buf (
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Buffer channel
  byte_buf_if.store  chan
);

  logic [7:0] head_reg;
  logic [7:0] tail_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  // Handshakes
  assign chan.in_ready  = (count_reg != 2'd2);
  assign chan.out_valid = (count_reg != 2'd0);
  assign chan.out_data  = head_reg;
  assign push = chan.in_valid & chan.in_ready;
  assign pop  = chan.out_ready & chan.out_valid;

  // Occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 2'd0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'd1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'd1;
    end
  end

  // Entry storage; head always holds the oldest word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_reg <= 8'h00;
      tail_reg <= 8'h00;
    end else begin
      if (pop) begin
        head_reg <= (count_reg == 2'd2) ? tail_reg : chan.in_data;
      end else if (push && count_reg == 2'd0) begin
        head_reg <= chan.in_data;
      end
      if (push && ((count_reg == 2'd1 && !pop) || (count_reg == 2'd2 && pop))) begin
        tail_reg <= chan.in_data;
      end
    end
  end

endmodule : two_entry_buf

// >>> logic/vcom_uart.sv
// Board-side serial port toward the target with selectable hardware handshake
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module vcom_uart #(
  parameter int unsigned DIV_CEIL = vcom_pkg::DIV_CEIL
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line toward and from the target
  output logic             ser_out,
  input  wire logic        ser_in,
  // Flow control pins, active high
  output logic             clear_to_send,
  output logic             clear_to_send_oe,
  input  wire logic        request_to_send
);

  // ==========================================================================
  // Declarations
  vcom_pkg::handshake_type mode_reg;
  logic [15:0]             div_reg;
  logic                    overrun_reg;
  logic                    framing_reg;
  logic [31:0]             prdata_reg;
  logic                    cts_reg;
  logic                    cts_oe_reg;

  vcom_pkg::ser_state_type tx_state_reg;
  logic [15:0]             tx_cnt_reg;
  logic [2:0]              tx_bit_reg;
  logic [7:0]              tx_shift_reg;
  logic                    tx_out_reg;
  logic                    tx_gated;
  logic                    tx_start_ok;

  vcom_pkg::ser_state_type rx_state_reg;
  logic [15:0]             rx_cnt_reg;
  logic [2:0]              rx_bit_reg;
  logic [7:0]              rx_shift_reg;
  logic                    rx_push_reg;
  logic                    rx_overrun_set;
  logic                    rx_framing_set;

  logic                    setup_phase;
  logic                    access_phase;
  logic                    addr_hit;
  logic                    tx_write;
  logic                    rx_read;
  logic                    wr_done;
  logic [15:0]             div_req;
  logic [15:0]             div_next;
  logic [31:0]             status_word;
  logic [31:0]             read_word;

  byte_buf_if tx_chan ();
  byte_buf_if rx_chan ();

  // ==========================================================================
  // Buffers: words from software toward the target, and bytes from the target
  two_entry_buf tx_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .chan    (tx_chan)
  );

  two_entry_buf rx_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .chan    (rx_chan)
  );

  // ==========================================================================
  // APB decode
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_hit     = (paddr == vcom_pkg::OFS_CTRL)   || (paddr == vcom_pkg::OFS_BAUD) ||
                        (paddr == vcom_pkg::OFS_STATUS) || (paddr == vcom_pkg::OFS_TXDATA) ||
                        (paddr == vcom_pkg::OFS_RXDATA);
  assign tx_write     = access_phase & pwrite & (paddr == vcom_pkg::OFS_TXDATA);
  assign rx_read      = access_phase & ~pwrite & (paddr == vcom_pkg::OFS_RXDATA);

  // A data write waits in the access phase until the transmit buffer has room
  assign pready  = ~(tx_write & ~tx_chan.in_ready);
  assign pslverr = access_phase & ~addr_hit;
  assign wr_done = access_phase & pwrite & pready & addr_hit;
  assign prdata  = prdata_reg;

  // Software feeds the transmit buffer straight from the bus
  assign tx_chan.in_valid = tx_write;
  assign tx_chan.in_data  = pwdata[7:0];

  // Reading the receive data register consumes the oldest byte
  assign rx_chan.out_ready = rx_read;

  // ==========================================================================
  // Handshake mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= vcom_pkg::MODE_RESET;
    end else if (wr_done && paddr == vcom_pkg::OFS_CTRL) begin
      mode_reg <= vcom_pkg::handshake_type'(pwdata[vcom_pkg::CTRL_MODE_LSB +: 2]);
    end
  end

  // Bit period limited to the supported baud range
  assign div_req = pwdata[15:0];
  always_comb begin
    if (div_req < vcom_pkg::DIV_FLOOR) begin
      div_next = vcom_pkg::DIV_FLOOR;
    end else if (32'(div_req) > DIV_CEIL) begin
      div_next = 16'(DIV_CEIL);
    end else begin
      div_next = div_req;
    end
  end

  // Divisor register shared by transmitter and receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= vcom_pkg::DIV_RESET;
    end else if (wr_done && paddr == vcom_pkg::OFS_BAUD) begin
      div_reg <= div_next;
    end
  end

  // Sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
    end else begin
      if (rx_overrun_set) begin
        overrun_reg <= 1'b1;
      end else if (wr_done && paddr == vcom_pkg::OFS_STATUS && pwdata[vcom_pkg::STAT_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (rx_framing_set) begin
        framing_reg <= 1'b1;
      end else if (wr_done && paddr == vcom_pkg::OFS_STATUS && pwdata[vcom_pkg::STAT_FRAMING]) begin
        framing_reg <= 1'b0;
      end
    end
  end

  // Status word assembly
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[vcom_pkg::STAT_TX_SPACE]  = tx_chan.in_ready;
    status_word[vcom_pkg::STAT_RX_AVAIL]  = rx_chan.out_valid;
    status_word[vcom_pkg::STAT_TX_BUSY]   = (tx_state_reg != vcom_pkg::ser_idle) | tx_chan.out_valid;
    status_word[vcom_pkg::STAT_OVERRUN]   = overrun_reg;
    status_word[vcom_pkg::STAT_FRAMING]   = framing_reg;
    status_word[vcom_pkg::STAT_CTS_LEVEL] = cts_reg;
    status_word[vcom_pkg::STAT_RTS_LEVEL] = request_to_send;
  end

  // Read multiplexer; unmapped and write-only addresses read zero
  always_comb begin
    case (paddr)
      vcom_pkg::OFS_CTRL:   read_word = {30'h0000_0000, mode_reg};
      vcom_pkg::OFS_BAUD:   read_word = {16'h0000, div_reg};
      vcom_pkg::OFS_STATUS: read_word = status_word;
      vcom_pkg::OFS_RXDATA: read_word = {24'h00_0000, rx_chan.out_data};
      default:              read_word = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= read_word;
    end
  end

  // ==========================================================================
  // Clear-to-send toward the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_reg    <= 1'b1;
      cts_oe_reg <= 1'b0;
    end else begin
      case (mode_reg)
        vcom_pkg::hs_rts, vcom_pkg::hs_rtscts: begin
          cts_oe_reg <= 1'b1;
          cts_reg    <= rx_chan.in_ready;
        end
        default: begin
          cts_oe_reg <= 1'b0;
          cts_reg    <= 1'b1;
        end
      endcase
    end
  end

  assign clear_to_send    = cts_reg;
  assign clear_to_send_oe = cts_oe_reg;

  // ==========================================================================
  // Transmitter toward the target
  assign tx_gated    = (mode_reg == vcom_pkg::hs_cts) || (mode_reg == vcom_pkg::hs_rtscts);
  // Only a new character waits on request-to-send; other modes ignore it
  assign tx_start_ok = ~tx_gated | request_to_send;
  assign tx_chan.out_ready = (tx_state_reg == vcom_pkg::ser_idle) & tx_start_ok;
  assign ser_out = tx_out_reg;

  // Transmit state machine, start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= vcom_pkg::ser_idle;
      tx_cnt_reg   <= 16'h0000;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_out_reg   <= 1'b1;
    end else begin
      case (tx_state_reg)
        vcom_pkg::ser_idle: begin
          tx_out_reg <= 1'b1;
          if (tx_chan.out_valid && tx_start_ok) begin
            tx_shift_reg <= tx_chan.out_data;
            tx_out_reg   <= 1'b0;
            tx_cnt_reg   <= div_reg - 16'h0001;
            tx_state_reg <= vcom_pkg::ser_start;
          end
        end
        vcom_pkg::ser_start: begin
          if (tx_cnt_reg == 16'h0000) begin
            tx_out_reg   <= tx_shift_reg[0];
            tx_bit_reg   <= 3'h0;
            tx_cnt_reg   <= div_reg - 16'h0001;
            tx_state_reg <= vcom_pkg::ser_data;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        vcom_pkg::ser_data: begin
          // The character runs to its end whatever request-to-send does
          if (tx_cnt_reg == 16'h0000) begin
            tx_cnt_reg   <= div_reg - 16'h0001;
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg   <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == 3'(vcom_pkg::DATA_BITS - 1)) begin
              tx_out_reg   <= 1'b1;
              tx_state_reg <= vcom_pkg::ser_stop;
            end else begin
              tx_out_reg <= tx_shift_reg[1];
            end
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        vcom_pkg::ser_stop: begin
          if (tx_cnt_reg == 16'h0000) begin
            tx_state_reg <= vcom_pkg::ser_idle;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          tx_state_reg <= vcom_pkg::ser_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // Receiver from the target, sampling each bit at its middle
  assign rx_chan.in_valid = rx_push_reg;
  assign rx_chan.in_data  = rx_shift_reg;
  assign rx_overrun_set   = (rx_state_reg == vcom_pkg::ser_stop) && (rx_cnt_reg == 16'h0000) &&
                            ser_in && !rx_chan.in_ready;
  assign rx_framing_set   = (rx_state_reg == vcom_pkg::ser_stop) && (rx_cnt_reg == 16'h0000) && !ser_in;

  // Receive state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= vcom_pkg::ser_idle;
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_push_reg  <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      case (rx_state_reg)
        vcom_pkg::ser_idle: begin
          if (!ser_in) begin
            rx_cnt_reg   <= {1'b0, div_reg[15:1]};
            rx_state_reg <= vcom_pkg::ser_start;
          end
        end
        vcom_pkg::ser_start: begin
          if (rx_cnt_reg == 16'h0000) begin
            // A start bit gone high by its middle was a glitch
            rx_state_reg <= ser_in ? vcom_pkg::ser_idle : vcom_pkg::ser_data;
            rx_bit_reg   <= 3'h0;
            rx_cnt_reg   <= div_reg - 16'h0001;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        vcom_pkg::ser_data: begin
          if (rx_cnt_reg == 16'h0000) begin
            rx_shift_reg <= {ser_in, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            rx_cnt_reg   <= div_reg - 16'h0001;
            if (rx_bit_reg == 3'(vcom_pkg::DATA_BITS - 1)) begin
              rx_state_reg <= vcom_pkg::ser_stop;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        vcom_pkg::ser_stop: begin
          if (rx_cnt_reg == 16'h0000) begin
            // Good stop bit stores the byte if the buffer has room
            rx_push_reg  <= ser_in & rx_chan.in_ready;
            rx_state_reg <= vcom_pkg::ser_idle;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          rx_state_reg <= vcom_pkg::ser_idle;
        end
      endcase
    end
  end

endmodule : vcom_uart

// >>> test/vcom_uart_props.sv
// Port-level checker for the serial bridge
`timescale 1ns/1ps
module vcom_uart_props #(
  parameter int unsigned DIV_CEIL = vcom_pkg::DIV_CEIL
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial and handshake
  input wire logic        ser_out,
  input wire logic        ser_in,
  input wire logic        clear_to_send,
  input wire logic        clear_to_send_oe,
  input wire logic        request_to_send
);
  // ==========================================================================
  // Shadow of mode and divisor, frame timer
  logic        acc;
  logic        rx_pop;
  logic        unmapped;
  logic        start_now;
  logic [1:0]  mode_reg;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [19:0] tmr_reg;
  logic [19:0] lim9;
  logic        so_reg;

  // Decode of accepted transfers
  assign acc       = psel && penable && pready;
  assign rx_pop    = acc && !pwrite && paddr == vcom_pkg::OFS_RXDATA;
  assign unmapped  = paddr > vcom_pkg::OFS_RXDATA || paddr[1:0] != 2'h0;
  assign div_next  = pwdata[15:0] < vcom_pkg::DIV_FLOOR ? vcom_pkg::DIV_FLOOR :
                     pwdata[15:0] > DIV_CEIL ? 16'(DIV_CEIL) : pwdata[15:0];
  assign start_now = so_reg && !ser_out && tmr_reg == 20'h0;
  assign lim9      = 20'(div_reg) * 20'h9;

  // Settings taken by accepted writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 2'h0;
      div_reg  <= vcom_pkg::DIV_RESET;
    end else if (acc && pwrite && !pslverr) begin
      if (paddr == vcom_pkg::OFS_CTRL) mode_reg <= pwdata[1:0];
      if (paddr == vcom_pkg::OFS_BAUD) div_reg <= div_next;
    end
  end

  // Counts out ten bit times from each start bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_reg <= 20'h0;
      so_reg  <= 1'b1;
    end else begin
      so_reg <= ser_out;
      if (start_now) tmr_reg <= 20'(div_reg) * 20'ha - 20'h1;
      else if (tmr_reg != 20'h0) tmr_reg <= tmr_reg - 20'h1;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_oe_mode: assert property ($stable(mode_reg) [*2] |-> clear_to_send_oe == mode_reg[0])
    else $error("cts drive enable does not follow mode");
  a_cts_idle_high: assert property (!clear_to_send_oe |-> clear_to_send)
    else $error("undriven cts not high");
  a_rts_gate: assert property (start_now && mode_reg[1] |-> $past(request_to_send) || $past(request_to_send, 2))
    else $error("start bit sent while rts low");
  a_start_low: assert property (tmr_reg > lim9 |-> !ser_out)
    else $error("start bit too short");
  a_stop_high: assert property (tmr_reg != 20'h0 && tmr_reg <= 20'(div_reg) |-> ser_out)
    else $error("stop bit missing");
  a_cts_return: assert property (rx_pop && mode_reg[0] && !clear_to_send |-> ##[1:3] clear_to_send)
    else $error("cts not back after pop");
  a_pready_tx: assert property (!pready |-> psel && pwrite && paddr == vcom_pkg::OFS_TXDATA)
    else $error("wait state outside tx write");
  a_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
    else $error("error flag wrong for address");
  a_rd_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0 && !(pslverr && prdata != 32'h0))
    else $error("read data upper bits not zero");

  c_start: cover property (start_now);
  c_throttle: cover property (rx_pop && !clear_to_send);
  c_error: cover property (acc && pslverr);
endmodule : vcom_uart_props

bind vcom_uart vcom_uart_props #(.DIV_CEIL(DIV_CEIL)) vcom_uart_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ser_out(ser_out), .ser_in(ser_in), .clear_to_send(clear_to_send),
  .clear_to_send_oe(clear_to_send_oe), .request_to_send(request_to_send)
);

// >>> test/target_uart.sv
// Behavioural target UART with handshake pins
`timescale 1ns/1ps
module target_uart (
  // Clock
  input  wire logic pclk,
  // Serial lines and handshake
  input  wire logic ser_out,
  input  wire logic clear_to_send,
  output logic      ser_in,
  output logic      request_to_send
);
  int         div = 1736;
  logic       obey = 1'b0;
  logic       busy = 1'b0;
  logic       rts_lvl = 1'b0;
  logic [7:0] sh;
  logic [7:0] got[$];

  // Rts pin is always driven
  assign request_to_send = rts_lvl;
  initial ser_in = 1'b1;

  // Sends one frame, holding off while throttled
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    if (obey) begin
      @(negedge pclk);
      while (clear_to_send !== 1'b1) @(negedge pclk);
      @(posedge pclk);
    end
    for (int i = 0; i < 10; i++) begin
      ser_in <= f[i];
      repeat (div) @(posedge pclk);
    end
  endtask : send

  // Receives every frame, also one begun before rts fell
  initial begin
    forever begin
      @(negedge pclk);
      if (ser_out === 1'b0) begin
        busy = 1'b1;
        repeat (div / 2) @(negedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (div) @(negedge pclk);
          sh[i] = ser_out;
        end
        repeat (div) @(negedge pclk);
        if (ser_out === 1'b1) got.push_back(sh);
        busy = 1'b0;
      end
    end
  end
endmodule : target_uart

// >>> test/vcom_uart_tb.sv
// Self-checking bench for the serial bridge
`timescale 1ns/1ps
module vcom_uart_tb;
  localparam int unsigned CEIL = 300;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        pready, pslverr, ser_out, ser_in, slv;
  logic        clear_to_send, clear_to_send_oe, request_to_send;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;

  always #2.5 pclk = ~pclk;

  vcom_uart #(.DIV_CEIL(CEIL)) vcom_uart_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_out(ser_out), .ser_in(ser_in), .clear_to_send(clear_to_send),
    .clear_to_send_oe(clear_to_send_oe), .request_to_send(request_to_send));
  target_uart target_uart_i (.pclk(pclk), .ser_out(ser_out), .clear_to_send(clear_to_send),
    .ser_in(ser_in), .request_to_send(request_to_send));

  // ==========================================================================
  // Verdict and checks
  task results();
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; the answer is taken at the rising edge that sees pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdv);
  endtask : rd

  task pins(input logic [1:0] e, input string n);
    @(negedge pclk);
    chk(n, {30'h0, e}, {30'h0, clear_to_send_oe, clear_to_send});
    @(posedge pclk);
  endtask : pins

  task tx_expect(input int n, input logic [7:0] e);
    for (int i = 0; i < 30000 && target_uart_i.got.size() < n; i++) @(posedge pclk);
    chk("byte at target", {24'h0, e}, {24'h0, target_uart_i.got[n - 1]});
  endtask : tx_expect

  task held(input int n);
    repeat (3000) @(posedge pclk);
    chk("bytes at target", n, target_uart_i.got.size());
  endtask : held

  task throttled();
    for (int i = 0; i < 8000 && clear_to_send !== 1'b0; i++) @(negedge pclk);
    pins(2'h2, "throttle pins");
  endtask : throttled

  // Cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(vcom_pkg::OFS_BAUD, 32'h6c8, "baud reset");
    rd(vcom_pkg::OFS_CTRL, 32'h0, "mode reset");
    rd(vcom_pkg::OFS_STATUS, 32'h21, "status reset");
    rd(8'h14, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, slv});
    // Reset rate, handshake off, rts low ignored
    apb(1'b1, vcom_pkg::OFS_TXDATA, 32'ha5);
    tx_expect(1, 8'ha5);
    target_uart_i.send(8'h3c);
    rd(vcom_pkg::OFS_RXDATA, 32'h3c, "rx reset rate");
    pins(2'h1, "disabled pins");
    // Divisor clamped at both ends
    apb(1'b1, vcom_pkg::OFS_BAUD, 32'h10);
    rd(vcom_pkg::OFS_BAUD, 32'hd9, "baud floor");
    apb(1'b1, vcom_pkg::OFS_BAUD, 32'hffff);
    rd(vcom_pkg::OFS_BAUD, 32'h12c, "baud ceiling");
    apb(1'b1, vcom_pkg::OFS_BAUD, 32'hd9);
    target_uart_i.div = 217;
    target_uart_i.got.delete();
    // Rts gating, with rts dropped mid-character
    apb(1'b1, vcom_pkg::OFS_CTRL, 32'h2);
    apb(1'b1, vcom_pkg::OFS_TXDATA, 32'h5a);
    apb(1'b1, vcom_pkg::OFS_TXDATA, 32'hc3);
    rd(vcom_pkg::OFS_STATUS, 32'h24, "status gated");
    chk("tx space", 32'h0, {31'h0, rdv[vcom_pkg::STAT_TX_SPACE]});
    held(0);
    pins(2'h1, "cts mode pins");
    target_uart_i.rts_lvl <= 1'b1;
    for (int i = 0; i < 3000 && !target_uart_i.busy; i++) @(posedge pclk);
    target_uart_i.rts_lvl <= 1'b0;
    tx_expect(1, 8'h5a);
    held(1);
    target_uart_i.rts_lvl <= 1'b1;
    tx_expect(2, 8'hc3);
    // Throttle by cts, rts ignored for sending
    target_uart_i.got.delete();
    apb(1'b1, vcom_pkg::OFS_CTRL, 32'h1);
    target_uart_i.rts_lvl <= 1'b0;
    target_uart_i.obey = 1'b1;
    apb(1'b1, vcom_pkg::OFS_TXDATA, 32'h0f);
    tx_expect(1, 8'h0f);
    fork
      begin
        target_uart_i.send(8'h11);
        target_uart_i.send(8'h22);
        target_uart_i.send(8'h33);
      end
    join_none
    throttled();
    repeat (3000) @(posedge pclk);
    rd(vcom_pkg::OFS_STATUS, 32'h03, "status throttled");
    chk("no overrun", 32'h0, {31'h0, rdv[vcom_pkg::STAT_OVERRUN]});
    rd(vcom_pkg::OFS_RXDATA, 32'h11, "rx first");
    pins(2'h3, "cts back");
    throttled();
    rd(vcom_pkg::OFS_RXDATA, 32'h22, "rx second");
    rd(vcom_pkg::OFS_RXDATA, 32'h33, "rx third");
    rd(vcom_pkg::OFS_STATUS, 32'h21, "status drained");
    chk("rx drained", 32'h0, {31'h0, rdv[vcom_pkg::STAT_RX_AVAIL]});
    // Combined mode gates and drives
    target_uart_i.got.delete();
    apb(1'b1, vcom_pkg::OFS_CTRL, 32'h3);
    apb(1'b1, vcom_pkg::OFS_TXDATA, 32'h96);
    held(0);
    pins(2'h3, "combined pins");
    target_uart_i.rts_lvl <= 1'b1;
    tx_expect(1, 8'h96);
    results();
  end
endmodule : vcom_uart_tb
